// File: core/eac_defs.svh
// Offsets, field positions, reset values and timing counts of the access control block.
`ifndef EAC_DEFS_SVH
`define EAC_DEFS_SVH

`define EAC_CTRL_OFS 8'hd2
`define EAC_KEY_MSB 7
`define EAC_KEY_LSB 4
`define EAC_MAP_BIT 1
`define EAC_BUSY_BIT 0
`define EAC_KEY_FIRST 4'h5
`define EAC_KEY_SECOND 4'ha
`define EAC_BOOT_BASE 16'hf800
`define EAC_USER_TOP 16'h3fff
`define EAC_EE_PROG_MS 10
`define EAC_CLK_MHZ 50
`define EAC_EE_PROG_CYC (`EAC_EE_PROG_MS * 1000 * `EAC_CLK_MHZ)
`define EAC_SEC_RESET 8'h00

`endif

// File: core/eac_pkg.sv
// Types shared by the access control block.
package eac_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } eac_sfr_req_s;

   typedef struct packed {
      logic [15:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } eac_xdata_req_s;

   typedef struct packed {
      logic user;
      logic boot;
   } eac_code_sel_s;

   typedef enum logic [1:0] {
      EAC_SP_USER = 2'b00,
      EAC_SP_EXTRA_ROW = 2'b01,
      EAC_SP_SEC = 2'b10,
      EAC_SP_RSVD = 2'b11
   } eac_space_e;

   typedef enum logic [0:0] {
      EAC_KEY_IDLE = 1'b0,
      EAC_KEY_ARMED = 1'b1
   } eac_key_e;

   typedef enum logic [1:0] {
      EAC_EE_IDLE = 2'b00,
      EAC_EE_COPY = 2'b01,
      EAC_EE_WAIT = 2'b10
   } eac_ee_e;
endpackage

// File: core/eac_latch.sv
// Page-sized column latch buffer that remembers the page of the last load.
`timescale 1ns/1ps
`default_nettype none
module eac_latch #(
   parameter int PAGE_W = 4
) (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_wr,
   input wire logic [6:0] i_idx,
   input wire logic [PAGE_W-1:0] i_page,
   input wire logic [7:0] i_data,
   input wire logic i_clear,
   input wire logic [6:0] i_rd_idx,
   output logic [7:0] o_rd_data,
   output logic o_rd_loaded,
   output logic [PAGE_W-1:0] o_page
);
   logic [7:0] mem [0:127];
   logic [127:0] loaded;

   assign o_rd_data = mem[i_rd_idx];
   assign o_rd_loaded = loaded[i_rd_idx];

   always_ff @(posedge i_clk_sys) begin
      if (i_wr) begin
         mem[i_idx] <= i_data;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         loaded <= '0;
         o_page <= '0;
      end else begin
         // A load in the clearing cycle survives, so it is never lost silently.
         if (i_clear) begin
            loaded <= '0;
            o_page <= '0;
         end
         if (i_wr) begin
            loaded[i_idx] <= 1'b1;
            o_page <= i_page;
         end
      end
   end
endmodule // eac_latch
`default_nettype wire

// File: core/eac_top.sv
// EEPROM control register, EEPROM and code flash access control.
//
// What this block does
// - Busy flag in control bit 0 rises at programming start, holds throughout.
// - Hardware clears busy at completion; software writes never change it.
// - Control value 02h maps external-data accesses onto EEPROM and latches.
// - Writing 00h unmaps, external-data accesses return to ordinary XRAM.
// - Control bits 3 and 2 read undefined; software writes zero there.
// - Reset clears map bit and busy; upper six bits undefined.
// - EEPROM column latches accept 1 to 128 bytes before launch.
// - Main flash user space is 128 pages of 128 bytes.
// - Boot flash appears at F800h-FFFFh only while boot mapping enabled.
// - Main flash has a separate 128-byte extra row.
// - Security byte: upper nibble software writable, lower nibble parallel-mode only.
// - One 128-byte column latch is the only write path into main flash.
// - Main flash programming launched from main flash code is refused.
// - Boot flash is never writable by software.
// - Main flash programmable by parallel programmer and serial in-system path.
// - Keys must be consecutive instructions, otherwise the launch aborts.
// - EEPROM reads are unavailable while busy.
// - Only the page address of the last latch load is kept.
`include "eac_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module eac_top #(
   parameter int unsigned EE_PROG_CYCLES = `EAC_EE_PROG_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire eac_pkg::eac_sfr_req_s i_sfr,
   input wire logic i_instr_start,
   output logic [7:0] o_sfr_rdata,
   input wire eac_pkg::eac_xdata_req_s i_xdata,
   output logic [7:0] o_xdata_rdata,
   output logic o_xram_route,
   output logic o_ee_busy,
   output logic o_ee_rd_blocked,
   input wire logic i_boot_map_enable,
   input wire logic [15:0] i_code_addr,
   output eac_pkg::eac_code_sel_s o_code_sel,
   input wire logic i_flash_cl_wr,
   input wire logic [14:0] i_flash_cl_addr,
   input wire logic [7:0] i_flash_cl_data,
   input wire logic i_flash_launch,
   input wire eac_pkg::eac_space_e i_flash_space,
   input wire logic i_isp_launch,
   input wire logic i_par_launch,
   input wire logic i_par_sec_we,
   input wire logic [3:0] i_par_sec_lo,
   output logic o_flash_start,
   output eac_pkg::eac_space_e o_flash_space,
   output logic [7:0] o_flash_page,
   output logic o_flash_refused,
   output logic [7:0] o_security
);
   // ****************************************************************
   // Control register and key detection
   // ****************************************************************
   logic map_en;
   logic [3:0] key_field;
   eac_pkg::eac_key_e key_state;
   eac_pkg::eac_key_e next_key_state;
   logic key_gap;
   logic seen_start;
   eac_pkg::eac_ee_e ee_state;
   eac_pkg::eac_ee_e next_ee_state;

   wire ctrl_wr = i_sfr.wr && (i_sfr.addr == `EAC_CTRL_OFS);
   wire ctrl_rd = i_sfr.rd && (i_sfr.addr == `EAC_CTRL_OFS);
   wire [3:0] wr_key = i_sfr.wdata[`EAC_KEY_MSB:`EAC_KEY_LSB];
   wire ee_busy = (ee_state != eac_pkg::EAC_EE_IDLE);
   // A second instruction start before the next control write means another
   // instruction ran in between the two keys.
   wire gap_now = seen_start && i_instr_start;
   wire key_launch = ctrl_wr && (key_state == eac_pkg::EAC_KEY_ARMED)
      && (wr_key == `EAC_KEY_SECOND) && !key_gap && !ee_busy;

   always_comb begin
      next_key_state = key_state;
      if (ctrl_wr) begin
         if (wr_key == `EAC_KEY_FIRST) begin
            next_key_state = eac_pkg::EAC_KEY_ARMED;
         end else begin
            next_key_state = eac_pkg::EAC_KEY_IDLE;
         end
      end
   end

   // Bits 3 and 2 are not stored and read as zero, one legal undefined value.
   wire [7:0] ctrl_value = {key_field, 2'b00, map_en, ee_busy};

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         map_en <= 1'b0;
         key_state <= eac_pkg::EAC_KEY_IDLE;
         key_gap <= 1'b0;
         seen_start <= 1'b0;
      end else begin
         key_state <= next_key_state;
         if (ctrl_wr) begin
            map_en <= i_sfr.wdata[`EAC_MAP_BIT];
            key_gap <= 1'b0;
            seen_start <= 1'b0;
         end else if (key_state == eac_pkg::EAC_KEY_ARMED) begin
            seen_start <= seen_start || i_instr_start;
            key_gap <= key_gap || gap_now;
         end
      end
   end

   // The key nibble has no reset value, so it is left out of the reset.
   always_ff @(posedge i_clk_sys) begin
      if (ctrl_wr) begin
         key_field <= wr_key;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         o_sfr_rdata <= 8'h00;
      end else begin
         o_sfr_rdata <= ctrl_rd ? ctrl_value : 8'h00;
      end
   end

   // ****************************************************************
   // EEPROM array, latches and programming sequence
   // ****************************************************************
   logic [7:0] ee_mem [0:2047];
   logic [6:0] copy_idx;
   logic [31:0] wait_cnt;
   logic [7:0] ee_cl_data;
   logic ee_cl_loaded;
   logic [3:0] ee_cl_page;

   wire ee_acc = map_en;
   // Loads while busy are dropped; software is expected to wait for idle.
   wire ee_cl_wr = ee_acc && i_xdata.wr && !ee_busy;
   wire ee_done = (ee_state == eac_pkg::EAC_EE_WAIT)
      && (wait_cnt == EE_PROG_CYCLES - 1);

   eac_latch #(
      .PAGE_W(4)
   ) u_ee_latch (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_wr(ee_cl_wr),
      .i_idx(i_xdata.addr[6:0]),
      .i_page(i_xdata.addr[10:7]),
      .i_data(i_xdata.wdata),
      .i_clear(ee_done),
      .i_rd_idx(copy_idx),
      .o_rd_data(ee_cl_data),
      .o_rd_loaded(ee_cl_loaded),
      .o_page(ee_cl_page)
   );

   always_comb begin
      next_ee_state = ee_state;
      unique case (ee_state)
         eac_pkg::EAC_EE_IDLE: begin
            if (key_launch) begin
               next_ee_state = eac_pkg::EAC_EE_COPY;
            end
         end
         eac_pkg::EAC_EE_COPY: begin
            if (copy_idx == 7'h7f) begin
               next_ee_state = eac_pkg::EAC_EE_WAIT;
            end
         end
         eac_pkg::EAC_EE_WAIT: begin
            if (ee_done) begin
               next_ee_state = eac_pkg::EAC_EE_IDLE;
            end
         end
         default: begin
            next_ee_state = eac_pkg::EAC_EE_IDLE;
         end
      endcase
   end

   // Only the bytes actually loaded are rewritten; the rest of the page stays.
   always_ff @(posedge i_clk_sys) begin
      if ((ee_state == eac_pkg::EAC_EE_COPY) && ee_cl_loaded) begin
         ee_mem[{ee_cl_page, copy_idx}] <= ee_cl_data;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         ee_state <= eac_pkg::EAC_EE_IDLE;
         copy_idx <= 7'h00;
         wait_cnt <= 32'h0000_0000;
         o_ee_busy <= 1'b0;
         o_xram_route <= 1'b1;
         o_xdata_rdata <= 8'h00;
         o_ee_rd_blocked <= 1'b0;
      end else begin
         ee_state <= next_ee_state;
         o_ee_busy <= (next_ee_state != eac_pkg::EAC_EE_IDLE);
         copy_idx <= (ee_state == eac_pkg::EAC_EE_COPY) ? copy_idx + 7'h01 : 7'h00;
         wait_cnt <= (ee_state == eac_pkg::EAC_EE_WAIT) ? wait_cnt + 32'h0000_0001
            : 32'h0000_0000;
         o_xram_route <= ctrl_wr ? !i_sfr.wdata[`EAC_MAP_BIT] : !map_en;
         o_ee_rd_blocked <= ee_acc && i_xdata.rd && ee_busy;
         if (ee_acc && i_xdata.rd && !ee_busy) begin
            o_xdata_rdata <= ee_mem[i_xdata.addr[10:0]];
         end else if (ee_acc && i_xdata.rd) begin
            o_xdata_rdata <= 8'h00;
         end
      end
   end

   // ****************************************************************
   // Code flash mapping, latch and launch control
   // ****************************************************************
   logic [7:0] fl_cl_data;
   logic fl_cl_loaded;
   logic [7:0] fl_cl_page;
   logic exec_boot;

   wire boot_hit = i_boot_map_enable && (i_code_addr >= `EAC_BOOT_BASE);
   wire user_hit = !boot_hit && (i_code_addr <= `EAC_USER_TOP);
   // Reserved space names no array; the boot flash has no write path at all.
   wire space_ok = (i_flash_space != eac_pkg::EAC_SP_RSVD);
   wire hw_launch = (i_par_launch || i_isp_launch) && space_ok;
   wire sw_launch = i_flash_launch && space_ok && exec_boot;
   wire fl_go = hw_launch || sw_launch;
   wire sec_update = fl_go && (i_flash_space == eac_pkg::EAC_SP_SEC) && fl_cl_loaded;

   eac_latch #(
      .PAGE_W(8)
   ) u_fl_latch (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_wr(i_flash_cl_wr),
      .i_idx(i_flash_cl_addr[6:0]),
      .i_page(i_flash_cl_addr[14:7]),
      .i_data(i_flash_cl_data),
      .i_clear(fl_go),
      .i_rd_idx(7'h00),
      .o_rd_data(fl_cl_data),
      .o_rd_loaded(fl_cl_loaded),
      .o_page(fl_cl_page)
   );

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         exec_boot <= 1'b0;
         o_code_sel <= '0;
         o_flash_start <= 1'b0;
         o_flash_space <= eac_pkg::EAC_SP_USER;
         o_flash_page <= 8'h00;
         o_flash_refused <= 1'b0;
         o_security <= `EAC_SEC_RESET;
      end else begin
         exec_boot <= boot_hit;
         o_code_sel <= '{user: user_hit, boot: boot_hit};
         o_flash_start <= fl_go;
         o_flash_refused <= (i_flash_launch || i_par_launch || i_isp_launch) && !fl_go;
         if (fl_go) begin
            o_flash_space <= i_flash_space;
            o_flash_page <= fl_cl_page;
         end
         if (sec_update) begin
            o_security[7:4] <= fl_cl_data[7:4];
         end
         if (i_par_sec_we) begin
            o_security[3:0] <= i_par_sec_lo;
         end
      end
   end
endmodule // eac_top
`default_nettype wire

// File: verification/eac_top_monitor.sv
// Concurrent checks on the ports of the access control block.
`timescale 1ns/1ps
`default_nettype none
module eac_top_monitor (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire eac_pkg::eac_sfr_req_s i_sfr,
   input wire eac_pkg::eac_xdata_req_s i_xdata,
   input wire logic [7:0] o_sfr_rdata,
   input wire logic [7:0] o_xdata_rdata,
   input wire logic o_xram_route,
   input wire logic o_ee_busy,
   input wire logic o_ee_rd_blocked,
   input wire logic i_boot_map_enable,
   input wire logic [15:0] i_code_addr,
   input wire eac_pkg::eac_code_sel_s o_code_sel,
   input wire logic i_flash_launch,
   input wire logic i_isp_launch,
   input wire logic i_par_launch,
   input wire logic i_par_sec_we,
   input wire logic [3:0] i_par_sec_lo,
   input wire logic o_flash_start,
   input wire logic o_flash_refused,
   input wire logic [7:0] o_security
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);
   wire ctl_wr = i_sfr.wr && i_sfr.addr == 8'hd2;
   wire key2_wr = ctl_wr && i_sfr.wdata[7:4] == 4'ha;
   wire map_w = i_sfr.wdata[1];
   wire boot_hit = i_boot_map_enable && i_code_addr >= 16'hf800;
   sequence s_launch;
      $past(key2_wr) || $past(key2_wr, 2);
   endsequence
   sequence s_busy_run;
      o_ee_busy [*8];
   endsequence
   a_busy_from_key: assert property ($rose(o_ee_busy) |-> s_launch)
      else $error("busy rose without a second key write");
   a_busy_holds: assert property ($rose(o_ee_busy) |-> s_busy_run)
      else $error("busy dropped early");
   a_busy_no_sw: assert property (ctl_wr && !key2_wr && !$past(key2_wr) && !o_ee_busy
      |=> !o_ee_busy)
      else $error("control write set busy");
   a_map_route: assert property (ctl_wr |=> o_xram_route == !$past(map_w))
      else $error("route does not follow map bit");
   a_ctl_read: assert property (i_sfr.rd && i_sfr.addr == 8'hd2
      |=> o_sfr_rdata[3:0] == {2'b00, !$past(o_xram_route), $past(o_ee_busy)})
      else $error("control read value wrong");
   a_rd_blocked: assert property (i_xdata.rd && !o_xram_route && o_ee_busy
      |=> o_ee_rd_blocked && o_xdata_rdata == 8'h00)
      else $error("read during busy not blocked");
   a_boot_map: assert property (1'b1 |=> o_code_sel.boot == $past(boot_hit))
      else $error("boot select wrong");
   a_main_refuse: assert property (i_flash_launch && !o_code_sel.boot && !i_isp_launch
      && !i_par_launch |=> o_flash_refused && !o_flash_start)
      else $error("launch from main flash accepted");
   a_sec_low: assert property (i_par_sec_we |=> o_security[3:0] == $past(i_par_sec_lo))
      else $error("security low nibble not written");
endmodule // eac_top_monitor
bind eac_top eac_top_monitor eac_top_monitor_i (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
   .i_sfr(i_sfr), .i_xdata(i_xdata), .o_sfr_rdata(o_sfr_rdata), .o_xdata_rdata(o_xdata_rdata),
   .o_xram_route(o_xram_route), .o_ee_busy(o_ee_busy), .o_ee_rd_blocked(o_ee_rd_blocked),
   .i_boot_map_enable(i_boot_map_enable), .i_code_addr(i_code_addr), .o_code_sel(o_code_sel),
   .i_flash_launch(i_flash_launch), .i_isp_launch(i_isp_launch), .i_par_launch(i_par_launch),
   .i_par_sec_we(i_par_sec_we), .i_par_sec_lo(i_par_sec_lo), .o_flash_start(o_flash_start),
   .o_flash_refused(o_flash_refused), .o_security(o_security));
`default_nettype wire

// File: verification/eac_cpu_model.sv
// Behavioural CPU core issuing control register and external-data accesses.
`timescale 1ns/1ps
`default_nettype none
module eac_cpu_model (
   input wire logic i_clk_sys,
   input wire logic i_ee_busy,
   input wire logic [7:0] i_sfr_rdata,
   input wire logic [7:0] i_xdata_rdata,
   output var eac_pkg::eac_sfr_req_s o_sfr,
   output var eac_pkg::eac_xdata_req_s o_xdata,
   output var logic o_instr_start
);
   initial begin
      o_sfr = '0;
      o_xdata = '0;
      o_instr_start = 1'b0;
   end
   // An idle data bus shows the inverse of the last value, never a stale copy.
   task automatic sfr(input logic rd, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q);
      @(posedge i_clk_sys) #1;
      o_sfr = '{addr: a, wr: !rd, rd: rd, wdata: d};
      @(posedge i_clk_sys) #1;
      q = i_sfr_rdata;
      o_sfr = '{addr: a, wr: 1'b0, rd: 1'b0, wdata: ~d};
   endtask
   task automatic xd(input logic rd, input logic [15:0] a, input logic [7:0] d,
      output logic [7:0] q);
      @(posedge i_clk_sys) #1;
      o_xdata = '{addr: a, wr: !rd, rd: rd, wdata: d};
      @(posedge i_clk_sys) #1;
      q = i_xdata_rdata;
      o_xdata = '{addr: a, wr: 1'b0, rd: 1'b0, wdata: ~d};
   endtask
   task automatic key(input int gaps);
      logic [7:0] q;
      sfr(1'b0, 8'hd2, 8'h50, q);
      repeat (gaps) begin
         @(posedge i_clk_sys) #1;
         o_instr_start = 1'b1;
         @(posedge i_clk_sys) #1;
         o_instr_start = 1'b0;
      end
      sfr(1'b0, 8'hd2, 8'ha0, q);
   endtask
   task automatic wait_idle;
      for (int n = 0; n < 400 && i_ee_busy; n++) @(posedge i_clk_sys) #1;
   endtask
endmodule // eac_cpu_model
`default_nettype wire

// File: verification/eac_top_tb_top.sv
// Self-checking bench for the access control block.
`timescale 1ns/1ps
`default_nettype none
module eac_top_tb_top;
   localparam int unsigned N = 8;
   logic i_clk_sys = 1'b0;
   logic i_rstn = 1'b0;
   eac_pkg::eac_sfr_req_s sfr;
   eac_pkg::eac_xdata_req_s xd;
   eac_pkg::eac_code_sel_s csel;
   eac_pkg::eac_space_e space = eac_pkg::EAC_SP_USER;
   eac_pkg::eac_space_e fspace;
   logic instr, route, busy, blk, start, refused, cl_wr = 1'b0;
   logic boot_en = 1'b0, launch = 1'b0, par = 1'b0, par_we = 1'b0, isp = 1'b0;
   logic [7:0] srd, xrd, fpage, sec, v, cl_data = '0;
   logic [15:0] caddr = '0;
   logic [14:0] cl_addr = '0;
   logic [3:0] sec_lo = '0;
   logic [7:0] row_w [5] = '{8'h02, 8'h62, 8'h01, 8'h31, 8'h00};
   logic [7:0] row_r [5] = '{8'h02, 8'h62, 8'h00, 8'h30, 8'h00};
   int mismatches = 0, checks = 0, n;
   eac_top #(.EE_PROG_CYCLES(N)) eac_top_i (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
      .i_sfr(sfr), .i_instr_start(instr), .o_sfr_rdata(srd), .i_xdata(xd), .o_xdata_rdata(xrd),
      .o_xram_route(route), .o_ee_busy(busy), .o_ee_rd_blocked(blk),
      .i_boot_map_enable(boot_en), .i_code_addr(caddr), .o_code_sel(csel), .i_flash_cl_wr(cl_wr),
      .i_flash_cl_addr(cl_addr), .i_flash_cl_data(cl_data), .i_flash_launch(launch),
      .i_flash_space(space), .i_isp_launch(isp), .i_par_launch(par), .i_par_sec_we(par_we),
      .i_par_sec_lo(sec_lo), .o_flash_start(start), .o_flash_space(fspace),
      .o_flash_page(fpage), .o_flash_refused(refused), .o_security(sec));
   eac_cpu_model cpu (.i_clk_sys(i_clk_sys), .i_ee_busy(busy), .i_sfr_rdata(srd),
      .i_xdata_rdata(xrd), .o_sfr(sfr), .o_xdata(xd), .o_instr_start(instr));
   always #10 i_clk_sys = ~i_clk_sys;
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      if (mismatches == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic step;
      @(posedge i_clk_sys) #1;
   endtask
   task automatic ld(input logic [14:0] a);
      step;
      cl_wr = 1'b1;
      cl_addr = a;
      cl_data = a[7:0];
      step;
      cl_wr = 1'b0;
   endtask
   task automatic fl(input logic l, input logic p, input logic ok);
      step;
      launch = l;
      par = p;
      step;
      launch = 1'b0;
      par = 1'b0;
      chk("start", start, ok);
      chk("refused", refused, !ok);
   endtask
   initial begin
      repeat (12) @(posedge i_clk_sys);
      #1 i_rstn = 1'b1;
      chk("route", route, 1'b1);
      chk("busy", busy, 1'b0);
      cpu.sfr(1'b1, 8'hd2, 8'h00, v);
      chk("ctl_low", v[1:0], 2'b00);
      cpu.sfr(1'b1, 8'hd3, 8'h00, v);
      chk("unmapped", v, 8'h00);
      for (int i = 0; i < 5; i++) begin
         cpu.sfr(1'b0, 8'hd2, row_w[i], v);
         chk("route_w", route, !row_w[i][1]);
         cpu.sfr(1'b1, 8'hd2, 8'h00, v);
         chk("ctl_rd", v, row_r[i]);
      end
      cpu.sfr(1'b0, 8'hd2, 8'h02, v);
      cpu.xd(1'b0, 16'h0005, 8'ha5, v);
      cpu.xd(1'b0, 16'h0086, 8'hc3, v);
      cpu.key(1);
      n = busy;
      repeat (300) begin
         step;
         n += busy;
      end
      chk("busy_len", n, 128 + N);
      cpu.sfr(1'b0, 8'hd2, 8'h02, v);
      cpu.xd(1'b1, 16'h0085, 8'h00, v);
      chk("last_page", v, 8'ha5);
      cpu.xd(1'b1, 16'h0086, 8'h00, v);
      chk("ee_data", v, 8'hc3);
      cpu.xd(1'b0, 16'h0010, 8'h77, v);
      cpu.key(1);
      cpu.sfr(1'b0, 8'hd2, 8'h02, v);
      cpu.xd(1'b1, 16'h0010, 8'h00, v);
      chk("blocked", blk, 1'b1);
      chk("blk_data", v, 8'h00);
      chk("busy_on", busy, 1'b1);
      cpu.wait_idle;
      cpu.key(2);
      step;
      chk("abort_gap", busy, 1'b0);
      cpu.sfr(1'b0, 8'hd2, 8'h50, v);
      cpu.sfr(1'b0, 8'hd2, 8'h00, v);
      cpu.sfr(1'b0, 8'hd2, 8'ha0, v);
      step;
      chk("abort_mid", busy, 1'b0);
      boot_en = 1'b1;
      caddr = 16'hf900;
      ld(15'h0105);
      ld(15'h0185);
      fl(1'b1, 1'b0, 1'b1);
      chk("page", fpage, 8'h03);
      chk("boot_sel", csel.boot, 1'b1);
      caddr = 16'h0100;
      step;
      chk("user_sel", csel.user, 1'b1);
      fl(1'b1, 1'b0, 1'b0);
      space = eac_pkg::EAC_SP_EXTRA_ROW;
      fl(1'b0, 1'b1, 1'b1);
      chk("space_extra_row", fspace, eac_pkg::EAC_SP_EXTRA_ROW);
      boot_en = 1'b0;
      caddr = 16'hf900;
      step;
      chk("boot_off", csel.boot, 1'b0);
      fl(1'b1, 1'b0, 1'b0);
      step;
      isp = 1'b1;
      step;
      isp = 1'b0;
      chk("isp_start", start, 1'b1);
      chk("isp_refused", refused, 1'b0);
      space = eac_pkg::EAC_SP_RSVD;
      fl(1'b0, 1'b1, 1'b0);
      ld(15'h0080);
      space = eac_pkg::EAC_SP_SEC;
      fl(1'b0, 1'b1, 1'b1);
      chk("space_sec", fspace, eac_pkg::EAC_SP_SEC);
      par_we = 1'b1;
      sec_lo = 4'h9;
      step;
      par_we = 1'b0;
      step;
      chk("sec_lo", sec[3:0], 4'h9);
      chk("sec", sec, 8'h89);
      tally_and_finish;
   end
   initial begin
      #(20 * 5000);
      mismatches++;
      tally_and_finish;
   end
endmodule // eac_top_tb_top
`default_nettype wire
